// ===== common/bce_pkg.sv
package bce_pkg;

  // Opcodes
  localparam logic [7:0] OPC_BIT_TOGGLE   = 8'h57;
  localparam logic [7:0] OPC_BIT_CLRSET   = 8'h77;
  localparam logic [7:0] OPC_BIT_OR       = 8'h07;
  localparam logic [7:0] OPC_BIT_XOR      = 8'h27;
  localparam logic [7:0] OPC_BRANCH_BIT   = 8'h37;
  localparam logic [7:0] OPC_CALL_DIRECT  = 8'hf6;
  localparam logic [7:0] OPC_CALL_PAIR    = 8'hf4;
  localparam logic [7:0] OPC_CALL_VECTOR  = 8'hd4;

  // Byte and cycle counts
  localparam logic [3:0] LEN_TWO          = 4'h2;
  localparam logic [3:0] LEN_THREE        = 4'h3;
  localparam logic [4:0] CYC_BIT_SHORT    = 5'h04;
  localparam logic [4:0] CYC_BIT_LONG     = 5'h06;
  localparam logic [4:0] CYC_BRANCH       = 5'h0a;
  localparam logic [4:0] CYC_CALL_DIRECT  = 5'h0e;
  localparam logic [4:0] CYC_CALL_PAIR    = 5'h0c;
  localparam logic [4:0] CYC_CALL_VECTOR  = 5'h0e;

  // Second-byte fields
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 4;
  localparam int BIT_MSB  = 3;
  localparam int BIT_LSB  = 1;
  localparam int VAR_POS  = 0;

  // Flag positions in the flag byte
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;

  // Working register bank base: working regs live at base upper nibble with the 4-bit index as low nibble
  localparam logic [7:0] WREG_BASE_RST    = 8'hc0;
  localparam logic [15:0] PC_RST          = 16'h0000;
  localparam logic [15:0] SP_RST          = 16'h0000;
  localparam logic [7:0] FLAGS_RST        = 8'h00;

  typedef enum logic [3:0] {
    BCE_IDLE   = 4'b0000,
    BCE_FETCH  = 4'b0001,
    BCE_OPND1  = 4'b0010,
    BCE_OPND2  = 4'b0011,
    BCE_READ_A = 4'b0100,
    BCE_READ_B = 4'b0101,
    BCE_VEC_HI = 4'b0110,
    BCE_VEC_LO = 4'b0111,
    BCE_EXEC   = 4'b1000,
    BCE_PUSH_L = 4'b1001,
    BCE_PUSH_H = 4'b1010,
    BCE_WAIT   = 4'b1011
  } bce_state_t;

  // Register file request
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bce_rf_req_t;

  // Stack (data memory) write request
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bce_stk_req_t;

endpackage : bce_pkg

// ===== rtl/bce_exec.sv
`timescale 1ns/1ps
module bce_exec
  import bce_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [7:0]   wreg_base,
  output logic              busy,
  output logic              done,
  output logic              illegal_op,
  output logic [15:0]       prog_addr,
  input  wire logic [7:0]   prog_data,
  output logic              vec_rd,
  output bce_rf_req_t       rf_req,
  input  wire logic [7:0]   rf_rdata,
  output bce_stk_req_t      stk_req,
  output logic [15:0]       pc_out,
  output logic [15:0]       stack_pointer_out,
  output logic [7:0]        flags_out
);

  // Program memory and register file are synchronous reads: address this
  // cycle, data next cycle. Each state therefore presents an address whose
  // data is consumed in the following state.

  function automatic logic [7:0] wreg_addr(input logic [7:0] base, input logic [3:0] idx);
    return {base[7:4], idx};
  endfunction

  function automatic logic [3:0] cycles_left(input logic [4:0] total, input logic [4:0] used);
    logic [4:0] diff;
    diff = total - used;
    return diff[3:0];
  endfunction

  bce_state_t  state_ff, nxt_state;
  logic [15:0] pc_ff;
  logic [15:0] sp_ff;
  logic [7:0]  flags_ff;
  logic [7:0]  opc_ff;
  logic [7:0]  op2_ff;
  logic [7:0]  op3_ff;
  logic [7:0]  val_a_ff;
  logic [7:0]  val_b_ff;
  logic [15:0] target_ff;
  logic [4:0]  cyc_ff;
  logic [4:0]  total_ff;
  logic        done_ff;
  logic        illegal_ff;
  logic [7:0]  base_ff;

  logic [3:0]  f_reg;
  logic [2:0]  f_bit;
  logic        f_var;
  logic        is_three;
  logic        is_call;
  logic        legal;

  assign f_reg = op2_ff[ADDR_MSB:ADDR_LSB];
  assign f_bit = op2_ff[BIT_MSB:BIT_LSB];
  assign f_var = op2_ff[VAR_POS];

  assign is_three = (opc_ff == OPC_BIT_OR) || (opc_ff == OPC_BIT_XOR) ||
                    (opc_ff == OPC_BRANCH_BIT) || (opc_ff == OPC_CALL_DIRECT);
  assign is_call  = (opc_ff == OPC_CALL_DIRECT) || (opc_ff == OPC_CALL_PAIR) ||
                    (opc_ff == OPC_CALL_VECTOR);

  always_comb begin
    legal = 1'b1;
    case (prog_data)
      OPC_BIT_TOGGLE, OPC_BIT_CLRSET, OPC_BIT_OR, OPC_BIT_XOR, OPC_BRANCH_BIT,
      OPC_CALL_DIRECT, OPC_CALL_PAIR, OPC_CALL_VECTOR: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end

  // Operation result: new destination byte and its single result bit
  logic [7:0]  res_byte;
  logic        res_bit;
  logic        bit_a;
  logic        lsb_b;
  logic [7:0]  w_byte;
  logic        is_short;
  // Short bit ops use read data as it arrives; a latch stage would break four cycles
  assign is_short = (opc_ff == OPC_BIT_TOGGLE) || (opc_ff == OPC_BIT_CLRSET);
  assign w_byte   = is_short ? rf_rdata : val_b_ff;
  always_comb begin
    bit_a    = val_a_ff[f_bit];
    lsb_b    = w_byte[0];
    res_byte = w_byte;
    res_bit  = 1'b0;
    case (opc_ff)
      OPC_BIT_TOGGLE: begin
        res_byte[f_bit] = ~w_byte[f_bit];
        res_bit         = ~w_byte[f_bit];
      end
      OPC_BIT_CLRSET: begin
        res_byte[f_bit] = f_var;
        res_bit         = f_var;
      end
      OPC_BIT_OR, OPC_BIT_XOR: begin
        // val_a holds the bit-b register, val_b the bit-zero register
        res_bit = (opc_ff == OPC_BIT_OR) ? (bit_a | lsb_b) : (bit_a ^ lsb_b);
        if (f_var == 1'b0) begin
          res_byte[0] = res_bit;
        end else begin
          res_byte        = val_a_ff;
          res_byte[f_bit] = res_bit;
        end
      end
      default: begin
        res_byte = w_byte;
        res_bit  = 1'b0;
      end
    endcase
  end

  logic [15:0] ret_addr;
  logic [15:0] br_target;
  assign ret_addr  = pc_ff + {12'h000, (is_three ? LEN_THREE : LEN_TWO)};
  assign br_target = ret_addr + {{8{op3_ff[7]}}, op3_ff};

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      BCE_IDLE:   if (start) nxt_state = BCE_FETCH;
      BCE_FETCH:  nxt_state = legal ? BCE_OPND1 : BCE_IDLE;
      BCE_OPND1:  nxt_state = is_three ? BCE_OPND2 : (is_short ? BCE_EXEC : BCE_READ_A);
      BCE_OPND2:  nxt_state = (opc_ff == OPC_BIT_OR || opc_ff == OPC_BIT_XOR) ? BCE_READ_A : BCE_EXEC;
      BCE_READ_A: nxt_state = (opc_ff == OPC_CALL_VECTOR) ? BCE_VEC_HI :
                              ((opc_ff == OPC_CALL_PAIR) ? BCE_READ_B : BCE_EXEC);
      BCE_READ_B: nxt_state = BCE_EXEC;
      BCE_VEC_HI: nxt_state = BCE_VEC_LO;
      BCE_VEC_LO: nxt_state = BCE_EXEC;
      BCE_EXEC:   nxt_state = is_call ? BCE_PUSH_L : BCE_WAIT;
      BCE_PUSH_L: nxt_state = BCE_PUSH_H;
      BCE_PUSH_H: nxt_state = BCE_WAIT;
      BCE_WAIT:   if (cycles_left(total_ff, cyc_ff) <= 4'h1) nxt_state = BCE_IDLE;
      default:    nxt_state = BCE_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) state_ff <= BCE_IDLE;
    else state_ff <= nxt_state;
  end

  // Cycle counter pads each instruction to its documented length
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cyc_ff   <= 5'h00;
      total_ff <= CYC_BIT_SHORT;
    end else if (state_ff == BCE_IDLE) begin
      cyc_ff <= 5'h00;
    end else begin
      cyc_ff <= cyc_ff + 5'h01;
      if (state_ff == BCE_FETCH) begin
        case (prog_data)
          OPC_BIT_TOGGLE, OPC_BIT_CLRSET: total_ff <= CYC_BIT_SHORT;
          OPC_BIT_OR, OPC_BIT_XOR:        total_ff <= CYC_BIT_LONG;
          OPC_BRANCH_BIT:                 total_ff <= CYC_BRANCH;
          OPC_CALL_DIRECT:                total_ff <= CYC_CALL_DIRECT;
          OPC_CALL_PAIR:                  total_ff <= CYC_CALL_PAIR;
          OPC_CALL_VECTOR:                total_ff <= CYC_CALL_VECTOR;
          default:                        total_ff <= CYC_BIT_SHORT;
        endcase
      end
    end
  end

  // Instruction bytes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opc_ff  <= 8'h00;
      op2_ff  <= 8'h00;
      op3_ff  <= 8'h00;
      base_ff <= WREG_BASE_RST;
    end else begin
      if (state_ff == BCE_IDLE && start) base_ff <= wreg_base;
      if (state_ff == BCE_FETCH) opc_ff <= prog_data;
      if (state_ff == BCE_OPND1) op2_ff <= prog_data;
      if (state_ff == BCE_OPND2) op3_ff <= prog_data;
    end
  end

  // Operand fetch: A is the full register (or odd pair half), B the working
  // register (or even pair half); each lands one state after its address
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      val_a_ff  <= 8'h00;
      val_b_ff  <= 8'h00;
      target_ff <= 16'h0000;
    end else begin
      if (state_ff == BCE_OPND2 || (state_ff == BCE_READ_A && !is_three)) val_b_ff <= rf_rdata;
      if ((state_ff == BCE_READ_A && is_three) || state_ff == BCE_READ_B) val_a_ff <= rf_rdata;
      if (state_ff == BCE_VEC_HI) target_ff[15:8] <= prog_data;
      if (state_ff == BCE_VEC_LO) target_ff[7:0] <= prog_data;
      if (state_ff == BCE_EXEC && opc_ff == OPC_CALL_DIRECT) target_ff <= {op2_ff, op3_ff};
      if (state_ff == BCE_EXEC && opc_ff == OPC_CALL_PAIR) target_ff <= {val_b_ff, val_a_ff};
    end
  end

  // Register file read address per state; OPND1 decodes the second byte as it arrives
  logic [7:0] rd_addr;
  always_comb begin
    rd_addr = wreg_addr(base_ff, f_reg);
    case (state_ff)
      BCE_OPND1: begin
        if (opc_ff == OPC_CALL_PAIR) rd_addr = wreg_addr(base_ff, {prog_data[BIT_MSB:BIT_LSB], 1'b0});
        else rd_addr = wreg_addr(base_ff, prog_data[ADDR_MSB:ADDR_LSB]);
      end
      BCE_OPND2:  rd_addr = prog_data;
      BCE_READ_A: rd_addr = wreg_addr(base_ff, {op2_ff[BIT_MSB:BIT_LSB], 1'b1});
      default:    rd_addr = wreg_addr(base_ff, f_reg);
    endcase
  end

  // Bit-b register: var 0 -> full register op3, var 1 -> full register op3 with
  // bit b as destination; working register always holds bit zero.
  always_comb begin
    rf_req = '0;
    case (state_ff)
      BCE_OPND1, BCE_OPND2, BCE_READ_A: rf_req.addr = rd_addr;
      BCE_EXEC: begin
        rf_req.addr = rd_addr;
        if (opc_ff == OPC_BIT_TOGGLE || opc_ff == OPC_BIT_CLRSET) begin
          rf_req.we    = 1'b1;
          rf_req.addr  = wreg_addr(base_ff, f_reg);
          rf_req.wdata = res_byte;
        end else if (opc_ff == OPC_BIT_OR || opc_ff == OPC_BIT_XOR) begin
          rf_req.we    = 1'b1;
          rf_req.addr  = f_var ? op3_ff : wreg_addr(base_ff, f_reg);
          rf_req.wdata = res_byte;
        end
      end
      default: rf_req = '0;
    endcase
  end

  always_comb begin
    stk_req = '0;
    if (state_ff == BCE_PUSH_L) begin
      stk_req.we    = 1'b1;
      stk_req.addr  = sp_ff - 16'h0001;
      stk_req.wdata = ret_addr[7:0];
    end else if (state_ff == BCE_PUSH_H) begin
      stk_req.we    = 1'b1;
      stk_req.addr  = sp_ff - 16'h0001;
      stk_req.wdata = ret_addr[15:8];
    end
  end

  always_comb begin
    prog_addr = pc_ff;
    vec_rd    = 1'b0;
    case (state_ff)
      BCE_FETCH:  prog_addr = pc_ff + 16'h0001;
      BCE_OPND1:  prog_addr = pc_ff + 16'h0002;
      BCE_READ_A: begin
        prog_addr = (opc_ff == OPC_CALL_VECTOR) ? {8'h00, op2_ff} : pc_ff; // Vector table entry
        vec_rd    = (opc_ff == OPC_CALL_VECTOR);
      end
      BCE_VEC_HI: begin
        prog_addr = {8'h00, op2_ff} + 16'h0001;
        vec_rd    = 1'b1;
      end
      default:    prog_addr = pc_ff;
    endcase
  end

  // Stack pointer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) sp_ff <= SP_RST;
    else if (state_ff == BCE_PUSH_L || state_ff == BCE_PUSH_H) sp_ff <= sp_ff - 16'h0001;
  end

  // Program counter; a call loads it only after both pushes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc_ff <= PC_RST;
    end else if (state_ff == BCE_PUSH_H) begin
      pc_ff <= target_ff;
    end else if (state_ff == BCE_EXEC && !is_call) begin
      if (opc_ff == OPC_BRANCH_BIT && (val_b_ff[f_bit] == f_var)) pc_ff <= br_target;
      else pc_ff <= ret_addr;
    end
  end

  // Flags: only invert/OR/XOR touch them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_ff <= FLAGS_RST;
    end else if (state_ff == BCE_EXEC &&
                 (opc_ff == OPC_BIT_TOGGLE || opc_ff == OPC_BIT_OR || opc_ff == OPC_BIT_XOR)) begin
      flags_ff[FLG_Z] <= (res_byte == 8'h00);
      flags_ff[FLG_S] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done_ff    <= 1'b0;
      illegal_ff <= 1'b0;
    end else begin
      done_ff    <= (state_ff == BCE_WAIT) && (nxt_state == BCE_IDLE);
      illegal_ff <= (state_ff == BCE_FETCH) && !legal;
    end
  end

  assign busy              = (state_ff != BCE_IDLE);
  assign done              = done_ff;
  assign illegal_op        = illegal_ff;
  assign pc_out            = pc_ff;
  assign stack_pointer_out = sp_ff;
  assign flags_out         = flags_ff;

endmodule // bce_exec

// ===== tb/bce_exec_props.sv
`timescale 1ns/1ps
module bce_exec_props
  import bce_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         rst,
  input wire logic         busy,
  input wire logic         done,
  input wire logic         illegal_op,
  input wire bce_rf_req_t  rf_req,
  input wire bce_stk_req_t stk_req,
  input wire logic [15:0]  pc_out,
  input wire logic [7:0]   flags_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held beyond one cycle");

  property p_push_order;
    $rose(stk_req.we) |=> stk_req.we && stk_req.addr == $past(stk_req.addr) - 16'h1 ##1 !stk_req.we;
  endproperty
  a_push_order: assert property (p_push_order) else $error("push pair out of order");

  property p_pc_hold_push;
    stk_req.we |-> $stable(pc_out);
  endproperty
  a_pc_hold_push: assert property (p_pc_hold_push) else $error("pc loaded before push ended");

  property p_flags_call;
    stk_req.we |-> $stable(flags_out);
  endproperty
  a_flags_call: assert property (p_flags_call) else $error("flags moved during call");

  property p_s_clear;
    $changed(flags_out) |-> !flags_out[FLG_S];
  endproperty
  a_s_clear: assert property (p_s_clear) else $error("sign flag left set");

  property p_carry_kept;
    $stable(flags_out[FLG_C]);
  endproperty
  a_carry_kept: assert property (p_carry_kept) else $error("carry flag changed");

  property p_v_kept;
    $stable(flags_out[FLG_V]);
  endproperty
  a_v_kept: assert property (p_v_kept) else $error("overflow flag changed");

  property p_idle_quiet;
    !busy |-> !rf_req.we && !stk_req.we;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("write while idle");

  property p_illegal;
    illegal_op |-> !done && $stable(pc_out) ##1 !illegal_op;
  endproperty
  a_illegal: assert property (p_illegal) else $error("bad illegal opcode pulse");

  c_done: cover property (done);
  c_push: cover property ($fell(stk_req.we));
  c_illegal: cover property (illegal_op);
endmodule // bce_exec_props

bind bce_exec bce_exec_props u_bce_exec_props (.sys_clk(sys_clk), .rst(rst), .busy(busy), .done(done),
  .illegal_op(illegal_op), .rf_req(rf_req), .stk_req(stk_req), .pc_out(pc_out), .flags_out(flags_out));

// ===== tb/bce_mem_model.sv
`timescale 1ns/1ps
module bce_mem_model
  import bce_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic [15:0]  prog_addr,
  output logic [7:0]       prog_data,
  input wire bce_rf_req_t  rf_req,
  output logic [7:0]       rf_rdata,
  input wire bce_stk_req_t stk_req
);
  // Plain always: the bench preloads these arrays directly
  logic [7:0] prog [0:65535];
  logic [7:0] rf   [0:255];
  logic [7:0] stk  [0:65535];

  always @(posedge sys_clk) begin
    prog_data <= prog[prog_addr];
    rf_rdata  <= rf[rf_req.addr];
    if (rf_req.we) rf[rf_req.addr] <= rf_req.wdata;
    if (stk_req.we) stk[stk_req.addr] <= stk_req.wdata;
  end
endmodule // bce_mem_model

// ===== tb/testbench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
  $display("ERROR %0t: mismatch got %0h exp %0h", $time, (got), (exp)); end end
module testbench;
  import bce_pkg::*;
  logic         sys_clk;
  logic         rst;
  logic         start;
  logic [7:0]   wreg_base;
  logic         busy, done, illegal_op, vec_rd, vec_seen;
  logic [15:0]  prog_addr, pc_out, stack_pointer_out, pc, ret;
  logic [7:0]   prog_data, rf_rdata, flags_out, fl;
  bce_rf_req_t  rf_req;
  bce_stk_req_t stk_req;
  int           fails, checks_done, n;

  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  bce_exec u_bce_exec (.sys_clk(sys_clk), .rst(rst), .start(start), .wreg_base(wreg_base), .busy(busy),
    .done(done), .illegal_op(illegal_op), .prog_addr(prog_addr), .prog_data(prog_data), .vec_rd(vec_rd),
    .rf_req(rf_req), .rf_rdata(rf_rdata), .stk_req(stk_req), .pc_out(pc_out),
    .stack_pointer_out(stack_pointer_out), .flags_out(flags_out));
  bce_mem_model u_bce_mem_model (.sys_clk(sys_clk), .prog_addr(prog_addr), .prog_data(prog_data),
    .rf_req(rf_req), .rf_rdata(rf_rdata), .stk_req(stk_req));

  always @(posedge sys_clk) if (vec_rd === 1'b1) vec_seen <= 1'b1;

  task end_of_test;
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task launch(input logic [7:0] b0, b1, b2);
    u_bce_mem_model.prog[pc] = b0;
    u_bce_mem_model.prog[pc + 16'h1] = b1;
    u_bce_mem_model.prog[pc + 16'h2] = b2;
    @(posedge sys_clk) start <= 1'b1;
    @(posedge sys_clk) start <= 1'b0;
    n = 0;
  endtask

  // Cycle count is measured from the edge that takes start
  task exec(input logic [7:0] b0, b1, b2, input int ncyc, input logic [15:0] nxt);
    launch(b0, b1, b2);
    do begin @(negedge sys_clk); n++; end while (done !== 1'b1 && n < 40);
    `CHK(n, ncyc + 1)
    `CHK(pc_out, nxt)
    pc = nxt;
  endtask

  initial begin
    #20000;
    fails++;
    end_of_test();
  end

  initial begin
    rst = 1'b1; start = 1'b0; wreg_base = 8'hc0; pc = 16'h0000;
    fails = 0; checks_done = 0; vec_seen = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    `CHK({pc_out, stack_pointer_out, flags_out, busy}, {16'h0000, 16'h0000, 8'h00, 1'b0})
    exec(OPC_CALL_DIRECT, 8'h02, 8'h00, 14, 16'h0200);
    `CHK(u_bce_mem_model.stk[16'hffff], 8'h03)
    `CHK(u_bce_mem_model.stk[16'hfffe], 8'h00)
    `CHK(stack_pointer_out, 16'hfffe)
    u_bce_mem_model.rf[8'hc1] = 8'h07;
    exec(OPC_BIT_TOGGLE, 8'h12, 8'h00, 4, pc + 16'h2);
    `CHK(u_bce_mem_model.rf[8'hc1], 8'h05)
    `CHK(flags_out[FLG_Z], 1'b0)
    u_bce_mem_model.rf[8'hc2] = 8'h01;
    exec(OPC_BIT_TOGGLE, 8'h20, 8'h00, 4, pc + 16'h2);
    `CHK({u_bce_mem_model.rf[8'hc2], flags_out}, {8'h00, 8'h40})
    u_bce_mem_model.rf[8'hc1] = 8'h07;
    exec(OPC_BIT_CLRSET, 8'h12, 8'h00, 4, pc + 16'h2);
    `CHK(u_bce_mem_model.rf[8'hc1], 8'h05)
    exec(OPC_BIT_CLRSET, 8'h17, 8'h00, 4, pc + 16'h2);
    `CHK({u_bce_mem_model.rf[8'hc1], flags_out}, {8'h0d, 8'h40})
    u_bce_mem_model.rf[8'hc3] = 8'h06;
    u_bce_mem_model.rf[8'h01] = 8'h03;
    exec(OPC_BIT_OR, 8'h32, 8'h01, 6, pc + 16'h3);
    `CHK({u_bce_mem_model.rf[8'hc3], u_bce_mem_model.rf[8'h01]}, 16'h0703)
    `CHK(flags_out[FLG_Z], 1'b0)
    exec(OPC_BIT_OR, 8'h35, 8'h01, 6, pc + 16'h3);
    `CHK({u_bce_mem_model.rf[8'hc3], u_bce_mem_model.rf[8'h01]}, 16'h0707)
    u_bce_mem_model.rf[8'hc3] = 8'h06;
    u_bce_mem_model.rf[8'h01] = 8'h03;
    exec(OPC_BIT_XOR, 8'h32, 8'h01, 6, pc + 16'h3);
    `CHK({u_bce_mem_model.rf[8'hc3], u_bce_mem_model.rf[8'h01]}, 16'h0703)
    u_bce_mem_model.rf[8'h01] = 8'h07;
    exec(OPC_BIT_XOR, 8'h35, 8'h01, 6, pc + 16'h3);
    `CHK({u_bce_mem_model.rf[8'hc3], u_bce_mem_model.rf[8'h01]}, 16'h0703)
    fl = flags_out;
    exec(OPC_BRANCH_BIT, 8'h12, 8'h80, 10, pc + 16'h3 - 16'h0080);
    exec(OPC_BRANCH_BIT, 8'h16, 8'h80, 10, pc + 16'h3);
    exec(OPC_BRANCH_BIT, 8'h17, 8'h7f, 10, pc + 16'h3 + 16'h007f);
    exec(OPC_BRANCH_BIT, 8'h13, 8'h7f, 10, pc + 16'h3);
    `CHK(flags_out, fl)
    u_bce_mem_model.rf[8'hc0] = 8'h12;
    u_bce_mem_model.rf[8'hc1] = 8'h34;
    ret = pc + 16'h2;
    exec(OPC_CALL_PAIR, 8'h20, 8'h00, 12, 16'h1234);
    `CHK({u_bce_mem_model.stk[16'hfffc], u_bce_mem_model.stk[16'hfffd]}, ret)
    `CHK(stack_pointer_out, 16'hfffc)
    u_bce_mem_model.prog[16'h0040] = 8'h05;
    u_bce_mem_model.prog[16'h0041] = 8'h00;
    ret = pc + 16'h2;
    exec(OPC_CALL_VECTOR, 8'h40, 8'h00, 14, 16'h0500);
    `CHK({u_bce_mem_model.stk[16'hfffa], u_bce_mem_model.stk[16'hfffb]}, ret)
    `CHK({stack_pointer_out, flags_out, vec_seen}, {16'hfffa, fl, 1'b1})
    // Unlisted opcode must not move the program counter
    launch(8'h00, 8'h00, 8'h00);
    do begin @(negedge sys_clk); n++; end while (illegal_op !== 1'b1 && n < 10);
    `CHK(illegal_op, 1'b1)
    `CHK(pc_out, 16'h0500)
    repeat (4) @(negedge sys_clk);
    // Reset in mid-instruction returns pc, stack pointer and busy to their reset values
    launch(OPC_CALL_DIRECT, 8'h03, 8'h00);
    repeat (3) @(posedge sys_clk);
    rst <= 1'b1;
    @(negedge sys_clk);
    `CHK({pc_out, stack_pointer_out, busy, stk_req.we}, {16'h0000, 16'h0000, 1'b0, 1'b0})
    @(posedge sys_clk) rst <= 1'b0;
    end_of_test();
  end
endmodule // testbench
